// [rtl/rvg_pkg.sv]
package rvg_pkg;

	// Register port widths
	typedef logic [11:0] rvg_addr_t;
	typedef logic [7:0] rvg_byte_t;

	// Writable register count and their table positions
	localparam int RVG_NWR = 7;
	localparam int IX_A2_ZERO_TEMP_COEFFICIENT = 0;
	localparam int IX_A2_TEMP_PROPORTIONAL_SENSOR = 1;
	localparam int IX_CROSS_Z = 2;
	localparam int IX_CROSS_P = 3;
	localparam int IX_CAP = 4;
	localparam int IX_AMUX = 5;
	localparam int IX_MFC = 6;

	// Writable register offsets
	localparam rvg_addr_t OFS_A2_ZERO_TEMP_COEFFICIENT = 12'h111;
	localparam rvg_addr_t OFS_A2_TEMP_PROPORTIONAL_SENSOR = 12'h112;
	localparam rvg_addr_t OFS_CROSS_Z = 12'h113;
	localparam rvg_addr_t OFS_CROSS_P = 12'h114;
	localparam rvg_addr_t OFS_CAP = 12'h115;
	localparam rvg_addr_t OFS_AMUX = 12'h120;
	localparam rvg_addr_t OFS_MFC = 12'h121;

	// Read-only register offsets
	localparam rvg_addr_t OFS_F_A1_MAIN = 12'h140;
	localparam rvg_addr_t OFS_F_A1_Z = 12'h141;
	localparam rvg_addr_t OFS_F_A1_P = 12'h142;
	localparam rvg_addr_t OFS_F_A2_MAIN = 12'h143;
	localparam rvg_addr_t OFS_F_A2_Z = 12'h144;
	localparam rvg_addr_t OFS_F_A2_P = 12'h145;
	localparam rvg_addr_t OFS_S_A1_Z = 12'h146;
	localparam rvg_addr_t OFS_S_A1_P = 12'h147;
	localparam rvg_addr_t OFS_S_A2_Z = 12'h148;
	localparam rvg_addr_t OFS_S_A2_P = 12'h149;
	localparam rvg_addr_t OFS_LIVE = 12'h14A;

	// Offsets, reset values and writable-bit masks, by table position
	localparam rvg_addr_t WR_OFS [RVG_NWR] = '{OFS_A2_ZERO_TEMP_COEFFICIENT, OFS_A2_TEMP_PROPORTIONAL_SENSOR,
		OFS_CROSS_Z, OFS_CROSS_P, OFS_CAP, OFS_AMUX, OFS_MFC};
	localparam rvg_byte_t WR_RST [RVG_NWR] = '{8'hAA, 8'h83, 8'h2A,
		8'h03, 8'h07, 8'h20, 8'h00};
	localparam rvg_byte_t WR_MASK [RVG_NWR] = '{8'hBF, 8'h8F, 8'h3F,
		8'h0F, 8'hFF, 8'hFF, 8'h1F};

	// Field positions
	localparam int USE_FUSED_BIT = 7;
	localparam int LEVEL_BIT = 4;
	localparam int A2_BYP_BIT = 7;
	localparam int A1_BYP_BIT = 6;

	// Largest legal attenuator code, 24 dB in 1 dB steps
	localparam logic [5:0] ATTEN_MAX = 6'h18;
	localparam rvg_byte_t ZERO_BYTE = 8'h00;

	// Host request toward the bank
	typedef struct packed {
		logic wr;
		logic rd;
		rvg_addr_t addr;
		rvg_byte_t wdata;
	} rvg_req_s;

	// Fused trim values from the fuse array
	typedef struct packed {
		logic [3:0] a1_main;
		logic [5:0] a1_z;
		logic [3:0] a1_p;
		logic [3:0] a2_main;
		logic [5:0] a2_z;
		logic [3:0] a2_p;
	} rvg_fuse_s;

	// Live path state from the rest of the unit
	typedef struct packed {
		logic a2_bypass;
		logic a1_bypass;
		logic [5:0] atten;
	} rvg_path_s;

	// Amplifier one cross trims in use
	typedef struct packed {
		logic [5:0] z;
		logic [3:0] p;
	} rvg_cross_s;

	// Trim and control outputs toward the analog section
	typedef struct packed {
		logic [5:0] a2_im3_zero_temp_trim;
		logic [3:0] a2_im3_prop_temp_trim;
		logic [5:0] a2_cross_zero_temp_trim;
		logic [3:0] a2_cross_prop_temp_trim;
		logic [3:0] a2_intermod_cap_trim;
		logic [3:0] spare_field;
		logic [2:0] monitor_output_select;
		logic unused_monitor_bit;
		logic [2:0] internal_monitor_select;
		logic readback_level_select;
	} rvg_trim_s;

	// Fuse image load sequence
	typedef enum logic {RVG_WAIT, RVG_DONE} rvg_load_e;

endpackage

// [rtl/rvg_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module rvg_regs (
	input wire logic ref_clk, // 250 MHz clock
	input wire logic reset_n, // Async reset, active low
	input wire rvg_pkg::rvg_req_s req_i, // Host register request
	output logic [7:0] rd_data_o, // Read data, registered
	output logic rd_valid_o, // Read data valid pulse
	input wire rvg_pkg::rvg_fuse_s fuse_i, // Fuse array values
	input wire logic fuse_valid_i, // Fuse values settled
	output logic fuse_loaded_o, // Fuse images captured
	input wire rvg_pkg::rvg_path_s path_i, // Live path state
	input wire rvg_pkg::rvg_cross_s a1_cross_i, // Amp one cross in use
	output rvg_pkg::rvg_trim_s trim_o // Trims to analog
);
	import rvg_pkg::*;

	// Synchronised reset copy
	logic rst_meta_q;
	logic rst_n;
	rvg_byte_t wr_q [RVG_NWR]; // Writable register images
	rvg_fuse_s fuse_q; // Captured fuse images
	rvg_load_e load_q; // Fuse load state
	rvg_path_s path_q; // Registered live path state
	rvg_byte_t rd_d; // Read mux result

	// Two-flop reset release; assertion is immediate
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// One flop per writable register; masked bits stay zero
	genvar gi;
	generate
		for (gi = 0; gi < RVG_NWR; gi++) begin : g_wr
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					wr_q[gi] <= WR_RST[gi];
				end else if (req_i.wr && req_i.addr == WR_OFS[gi]) begin
					// Reserved read-only bits drop the write
					wr_q[gi] <= req_i.wdata & WR_MASK[gi];
				end
			end
		end
	endgenerate

	// Fuse capture waits for the array; images read zero until then
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			load_q <= RVG_WAIT;
			fuse_q <= '0;
		end else begin
			case (load_q)
				RVG_WAIT: begin
					if (fuse_valid_i) begin
						fuse_q <= fuse_i;
						load_q <= RVG_DONE;
					end
				end
				RVG_DONE: begin
					// Captured once; later fuse activity is ignored
					load_q <= RVG_DONE;
				end
				default: begin
					load_q <= RVG_WAIT;
				end
			endcase
		end
	end
	assign fuse_loaded_o = (load_q == RVG_DONE);

	// Live state sampled each cycle; code clamped to legal range
	// A flop here costs one cycle of status lag but keeps the read
	// mux away from the asynchronous toggling of the path state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			path_q <= '0;
		end else begin
			path_q.a2_bypass <= path_i.a2_bypass;
			path_q.a1_bypass <= path_i.a1_bypass;
			// An out-of-range code would read as more than 24 dB
			path_q.atten <= (path_i.atten > ATTEN_MAX) ?
				ATTEN_MAX : path_i.atten;
		end
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		rd_d = ZERO_BYTE;
		case (req_i.addr)
			OFS_A2_ZERO_TEMP_COEFFICIENT: rd_d = wr_q[IX_A2_ZERO_TEMP_COEFFICIENT];
			OFS_A2_TEMP_PROPORTIONAL_SENSOR: rd_d = wr_q[IX_A2_TEMP_PROPORTIONAL_SENSOR];
			OFS_CROSS_Z: rd_d = wr_q[IX_CROSS_Z];
			OFS_CROSS_P: rd_d = wr_q[IX_CROSS_P];
			OFS_CAP: rd_d = wr_q[IX_CAP];
			OFS_AMUX: rd_d = wr_q[IX_AMUX];
			OFS_MFC: rd_d = wr_q[IX_MFC];
			OFS_F_A1_MAIN: rd_d = {4'h0, fuse_q.a1_main};
			OFS_F_A1_Z: rd_d = {2'h0, fuse_q.a1_z};
			OFS_F_A1_P: rd_d = {4'h0, fuse_q.a1_p};
			OFS_F_A2_MAIN: rd_d = {4'h0, fuse_q.a2_main};
			OFS_F_A2_Z: rd_d = {2'h0, fuse_q.a2_z};
			OFS_F_A2_P: rd_d = {4'h0, fuse_q.a2_p};
			OFS_S_A1_Z: rd_d = {2'h0, a1_cross_i.z};
			OFS_S_A1_P: rd_d = {4'h0, a1_cross_i.p};
			OFS_S_A2_Z: rd_d = {2'h0, trim_o.a2_cross_zero_temp_trim};
			OFS_S_A2_P: rd_d = {4'h0, trim_o.a2_cross_prop_temp_trim};
			OFS_LIVE: rd_d = path_q;
			default: rd_d = ZERO_BYTE;
		endcase
	end

	// Read answer one cycle after the request
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_o <= ZERO_BYTE;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= req_i.rd;
			if (req_i.rd) begin
				rd_data_o <= rd_d;
			end
		end
	end

	// Trim outputs; fused values win when their select bit is set
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_o <= '0;
		end else begin
			trim_o.a2_im3_zero_temp_trim <=
				wr_q[IX_A2_ZERO_TEMP_COEFFICIENT][USE_FUSED_BIT] ?
				fuse_q.a2_z : wr_q[IX_A2_ZERO_TEMP_COEFFICIENT][5:0];
			trim_o.a2_im3_prop_temp_trim <=
				wr_q[IX_A2_TEMP_PROPORTIONAL_SENSOR][USE_FUSED_BIT] ?
				fuse_q.a2_p : wr_q[IX_A2_TEMP_PROPORTIONAL_SENSOR][3:0];
			trim_o.a2_cross_zero_temp_trim <= wr_q[IX_CROSS_Z][5:0];
			trim_o.a2_cross_prop_temp_trim <= wr_q[IX_CROSS_P][3:0];
			trim_o.a2_intermod_cap_trim <= wr_q[IX_CAP][3:0];
			trim_o.spare_field <= wr_q[IX_CAP][7:4];
			trim_o.monitor_output_select <= wr_q[IX_AMUX][2:0];
			trim_o.unused_monitor_bit <= wr_q[IX_AMUX][3];
			trim_o.internal_monitor_select <= wr_q[IX_AMUX][6:4];
			trim_o.readback_level_select <=
				wr_q[IX_MFC][LEVEL_BIT];
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Host write to the zero-temp register
	sequence s_wr_zero_temp_coefficient;
		req_i.wr && req_i.addr == OFS_A2_ZERO_TEMP_COEFFICIENT;
	endsequence
	// Host read of the zero-temp register
	sequence s_rd_zero_temp_coefficient;
		req_i.rd && req_i.addr == OFS_A2_ZERO_TEMP_COEFFICIENT;
	endsequence
	// Idle bus cycle; the host leaves one between accesses
	sequence s_gap;
		!req_i.wr && !req_i.rd;
	endsequence

	// Stable fuse image reaches the trim one edge later
	a_zero_temp_coefficient_fused_sel: assert property (
		wr_q[IX_A2_ZERO_TEMP_COEFFICIENT][USE_FUSED_BIT] ##1
		$stable(fuse_q) && $stable(wr_q[IX_A2_ZERO_TEMP_COEFFICIENT]) |->
		trim_o.a2_im3_zero_temp_trim == fuse_q.a2_z)
		else $error("zero-temp trim not taken from fuse");
	// Written byte reads back with the reserved bit cleared
	a_zero_temp_coefficient_wr_rd: assert property (
		s_wr_zero_temp_coefficient ##1 s_gap ##1 s_rd_zero_temp_coefficient |->
		##1 rd_valid_o &&
		rd_data_o == ($past(req_i.wdata, 3) & WR_MASK[IX_A2_ZERO_TEMP_COEFFICIENT]))
		else $error("zero-temp register read differs from write");
	// Register field drives the trim when fuse select is off
	a_temp_proportional_sensor_field_sel: assert property (
		!wr_q[IX_A2_TEMP_PROPORTIONAL_SENSOR][USE_FUSED_BIT] ##1
		!wr_q[IX_A2_TEMP_PROPORTIONAL_SENSOR][USE_FUSED_BIT] |->
		trim_o.a2_im3_prop_temp_trim == $past(wr_q[IX_A2_TEMP_PROPORTIONAL_SENSOR][3:0]))
		else $error("prop-temp trim not taken from register");
	// Reserved prop-temp bits stay clear
	a_temp_proportional_sensor_resvd_zero: assert property (
		wr_q[IX_A2_TEMP_PROPORTIONAL_SENSOR][6:4] == 3'h0)
		else $error("reserved prop-temp bits set");
	// Reserved cross trim bits stay clear
	a_cross_resvd_zero: assert property (
		wr_q[IX_CROSS_Z][7:6] == 2'h0 && wr_q[IX_CROSS_P][7:4] == 4'h0)
		else $error("reserved cross trim bits set");
	// Level select follows a write two edges later
	a_level_follow: assert property (
		req_i.wr && req_i.addr == OFS_MFC |->
		##2 trim_o.readback_level_select == $past(req_i.wdata[LEVEL_BIT], 2))
		else $error("readback level did not follow write");
	// Reset values present on the first running edge
	a_reset_values: assert property (
		$rose(rst_n) |-> wr_q[IX_A2_ZERO_TEMP_COEFFICIENT] == 8'hAA &&
		wr_q[IX_AMUX] == 8'h20 && wr_q[IX_CAP] == 8'h07)
		else $error("register lost its reset value");
	// Images stay blank until the array reports settled
	a_fuse_zero_early: assert property (
		load_q == RVG_WAIT |-> fuse_q == '0)
		else $error("fuse image nonzero before load");
	// First settled strobe captures the whole image
	a_fuse_capture: assert property (
		load_q == RVG_WAIT && fuse_valid_i |->
		##1 fuse_loaded_o && fuse_q == $past(fuse_i))
		else $error("fuse image not captured");
	// Status byte carries both bypass bits
	a_live_status: assert property (
		req_i.rd && req_i.addr == OFS_LIVE |->
		##1 rd_data_o[A2_BYP_BIT] == $past(path_q.a2_bypass) &&
		rd_data_o[A1_BYP_BIT] == $past(path_q.a1_bypass))
		else $error("live path status mismatch");
	// Clamp keeps the status inside the legal range
	a_atten_range: assert property (
		path_q.atten <= ATTEN_MAX)
		else $error("attenuator status above 24 dB");
	// Holes in the map read as zero
	a_rd_unmapped: assert property (
		req_i.rd && req_i.addr == 12'h116 |-> ##1 rd_data_o == 8'h00)
		else $error("unmapped read not zero");

	// Reserved zero-temp bit never holds a one
	a_zero_temp_coefficient_resvd_zero: assert property (
		wr_q[IX_A2_ZERO_TEMP_COEFFICIENT][6] == 1'b0)
		else $error("reserved zero-temp bit set");

	// Upper read-only control bits stay clear
	a_level_resvd_zero: assert property (
		wr_q[IX_MFC][7:5] == 3'h0)
		else $error("reserved control bits set");

	// Valid is exactly the read strobe delayed one edge
	a_rd_valid_pulse: assert property (
		rd_valid_o == $past(req_i.rd))
		else $error("read valid not one cycle after read");

	// Once captured the image never moves until reset
	a_fuse_hold: assert property (
		fuse_loaded_o |=> fuse_loaded_o && $stable(fuse_q))
		else $error("fuse image changed after load");

	// Amplifier one main bias image read back
	a_fa1_main_rd: assert property (
		req_i.rd && req_i.addr == OFS_F_A1_MAIN |->
		##1 rd_data_o == {4'h0, $past(fuse_q.a1_main)})
		else $error("amp one main bias image mismatch");

	// Amplifier one zero-temp image read back
	a_fa1_z_rd: assert property (
		req_i.rd && req_i.addr == OFS_F_A1_Z |->
		##1 rd_data_o == {2'h0, $past(fuse_q.a1_z)})
		else $error("amp one zero-temp image mismatch");

	// Amplifier two zero-temp image read back
	a_fa2_z_rd: assert property (
		req_i.rd && req_i.addr == OFS_F_A2_Z |->
		##1 rd_data_o == {2'h0, $past(fuse_q.a2_z)})
		else $error("amp two zero-temp image mismatch");

	// Amplifier two prop-temp image read back
	a_fa2_p_rd: assert property (
		req_i.rd && req_i.addr == OFS_F_A2_P |->
		##1 rd_data_o == {4'h0, $past(fuse_q.a2_p)})
		else $error("amp two prop-temp image mismatch");

	// Amplifier one cross value passes straight through
	a_a1_cross_rd: assert property (
		req_i.rd && req_i.addr == OFS_S_A1_Z |->
		##1 rd_data_o == {2'h0, $past(a1_cross_i.z)})
		else $error("amp one cross status mismatch");

	// Amplifier two cross status shows the value in use
	a_a2_cross_rd: assert property (
		req_i.rd && req_i.addr == OFS_S_A2_P |->
		##1 rd_data_o == {4'h0, $past(trim_o.a2_cross_prop_temp_trim)})
		else $error("amp two cross status mismatch");

	// Attenuator code read back as sampled
	a_atten_rd: assert property (
		req_i.rd && req_i.addr == OFS_LIVE |->
		##1 rd_data_o[5:0] == $past(path_q.atten))
		else $error("attenuator status mismatch");

	// Trim flops lag the register by one edge; skip the release edge
	a_cap_out: assert property (
		$past(rst_n) |-> {trim_o.spare_field, trim_o.a2_intermod_cap_trim}
		== $past(wr_q[IX_CAP]))
		else $error("cap trim or spare output mismatch");

	// Cross zero-temp trim output follows its register
	a_cross_z_out: assert property (
		$past(rst_n) |->
		trim_o.a2_cross_zero_temp_trim == $past(wr_q[IX_CROSS_Z][5:0]))
		else $error("cross zero-temp output mismatch");

	// Cross prop-temp trim output follows its register
	a_cross_p_out: assert property (
		$past(rst_n) |->
		trim_o.a2_cross_prop_temp_trim == $past(wr_q[IX_CROSS_P][3:0]))
		else $error("cross prop-temp output mismatch");

	// Monitor multiplexer select follows its field
	a_monitor_out: assert property (
		$past(rst_n) |->
		trim_o.monitor_output_select == $past(wr_q[IX_AMUX][2:0]))
		else $error("monitor select output mismatch");

	// Internal select and unused bit follow their fields
	a_internal_mon: assert property (
		$past(rst_n) |-> {trim_o.internal_monitor_select,
		trim_o.unused_monitor_bit} == $past(wr_q[IX_AMUX][6:3]))
		else $error("internal monitor output mismatch");

	// Bypass bits are taken as given, no recoding
	a_bypass_live: assert property (
		$past(rst_n) |-> path_q.a1_bypass == $past(path_i.a1_bypass) &&
		path_q.a2_bypass == $past(path_i.a2_bypass))
		else $error("bypass status not sampled");

endmodule // rvg_regs
`default_nettype wire

// [tb/rvg_host.sv]
`timescale 1ns/100ps
`default_nettype none
// Host controller model, one byte access per call
module rvg_host (
	input wire logic ref_clk, // Bank clock
	output rvg_pkg::rvg_req_s req, // Request toward bank
	input wire logic [7:0] rd_data, // Read data
	input wire logic rd_valid // Read answer strobe
);
	import rvg_pkg::*;
	initial req = '0; // Idle from time zero
	// Write strobe for one edge, then idle
	task automatic put(input rvg_addr_t a, input rvg_byte_t d);
		@(posedge ref_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		req <= '0;
	endtask
	// Answer is registered; taken at the edge that sees valid high
	task automatic get(input rvg_addr_t a, output rvg_byte_t d);
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		req <= '0;
		@(posedge ref_clk);
		d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
	endtask
endmodule // rvg_host
`default_nettype wire

// [tb/test_rvg_regs.sv]
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the trim and readback bank
module test_rvg_regs;
	import rvg_pkg::*;
	logic ref_clk; // 250 MHz
	logic reset_n; // Active low
	rvg_req_s req; // From host model
	logic [7:0] rd_data; // Read data
	logic rd_valid; // Read answer
	rvg_fuse_s fuse; // Fuse array values
	logic fuse_valid; // Fuse settled
	logic fuse_loaded; // Images captured
	rvg_path_s path; // Live path state
	rvg_cross_s c; // Amp one cross in use
	rvg_trim_s trim; // Trims to analog
	rvg_byte_t s [RVG_NWR]; // Expected register contents
	rvg_fuse_s f; // Expected fuse images
	logic [31:0] rnd; // Random draw
	int error_cnt; // Mismatches
	int checked; // Comparisons
	int k; // Register pick
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	rvg_regs i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .req_i(req),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .fuse_i(fuse),
		.fuse_valid_i(fuse_valid), .fuse_loaded_o(fuse_loaded),
		.path_i(path), .a1_cross_i(c), .trim_o(trim));
	rvg_host i_host (.ref_clk(ref_clk), .req(req), .rd_data(rd_data),
		.rd_valid(rd_valid));
	// Case equality, so an unknown never matches
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Read one register and compare
	task automatic rd_chk(input rvg_addr_t a, input rvg_byte_t e);
		rvg_byte_t v;
		i_host.get(a, v);
		cmp(v, e);
	endtask
	// Write one register and track it
	task automatic wr(input int n, input rvg_byte_t d);
		i_host.put(WR_OFS[n], d);
		s[n] = d;
	endtask
	// Fused image of read-only offset 0x140 plus n
	function automatic rvg_byte_t fuse_img(int n, rvg_fuse_s v);
		case (n)
			0: return 8'(v.a1_main);
			1: return 8'(v.a1_z);
			2: return 8'(v.a1_p);
			3: return 8'(v.a2_main);
			4: return 8'(v.a2_z);
			default: return 8'(v.a2_p);
		endcase
	endfunction
	// Status byte; codes past 24 dB show as 24
	function automatic rvg_byte_t live_img(rvg_path_s p);
		return {p.a2_bypass, p.a1_bypass,
			(p.atten > ATTEN_MAX) ? ATTEN_MAX : p.atten};
	endfunction
	// Registers read back with reserved bits cleared
	task automatic check_regs();
		for (int n = 0; n < RVG_NWR; n++)
			rd_chk(WR_OFS[n], s[n] & WR_MASK[n]);
		for (int n = 0; n < 6; n++)
			rd_chk(rvg_addr_t'(OFS_F_A1_MAIN + n), fuse_img(n, f));
	endtask
	// Trim outputs; bit 7 picks the fused value
	task automatic check_trim();
		cmp(8'(trim.a2_im3_zero_temp_trim), 8'(s[0][7] ? f.a2_z : s[0][5:0]));
		cmp(8'(trim.a2_im3_prop_temp_trim), 8'(s[1][7] ? f.a2_p : s[1][3:0]));
		cmp(8'(trim.a2_cross_zero_temp_trim), 8'(s[2][5:0]));
		cmp(8'(trim.a2_cross_prop_temp_trim), 8'(s[3][3:0]));
		cmp(8'(trim.unused_monitor_bit), 8'(s[5][3]));
		cmp({trim.spare_field, trim.a2_intermod_cap_trim}, s[4]);
		cmp(8'(trim.monitor_output_select), 8'(s[5][2:0]));
		cmp(8'(trim.internal_monitor_select), 8'(s[5][6:4]));
		cmp(8'(trim.readback_level_select), 8'(s[6][4]));
	endtask
	// Reset, then reset values and blank fuse images
	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		s = WR_RST;
		f = '0;
		check_regs();
	endtask
	task automatic report_and_stop();
		$display("errors %0d, checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#40000;
		error_cnt++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		error_cnt = 0;
		checked = 0;
		reset_n = 1'b0;
		fuse = '0;
		fuse_valid = 1'b0;
		path = '0;
		c = '0;
		void'($urandom(32'h3331));
		do_reset();
		rnd = $urandom();
		fuse <= rnd[27:0];
		fuse_valid <= 1'b1;
		@(posedge ref_clk);
		fuse_valid <= 1'b0;
		f = rnd[27:0];
		@(posedge ref_clk);
		cmp(8'(fuse_loaded), 8'h01);
		fuse <= ~rnd[27:0];
		rnd = $urandom();
		c <= rnd[9:0];
		// All ones first, then random bytes; RO writes mixed in
		for (int n = 0; n < 24; n++) begin
			k = (n < RVG_NWR) ? n : $urandom_range(RVG_NWR - 1, 0);
			wr(k, (n < RVG_NWR) ? 8'hFF : 8'($urandom()));
			i_host.put(rvg_addr_t'(OFS_F_A1_MAIN + k), 8'hFF);
		end
		check_regs();
		check_trim();
		wr(0, 8'h15);
		rd_chk(OFS_A2_ZERO_TEMP_COEFFICIENT, s[0] & WR_MASK[0]);
		wr(1, 8'h0C);
		rd_chk(OFS_S_A1_Z, 8'(rnd[9:4]));
		rd_chk(OFS_S_A1_P, 8'(rnd[3:0]));
		rd_chk(OFS_S_A2_Z, s[2] & 8'h3F);
		rd_chk(OFS_S_A2_P, s[3] & 8'h0F);
		rd_chk(12'h116, ZERO_BYTE);
		check_trim();
		// Live state with 24 dB and an out-of-range code
		for (int n = 0; n < 8; n++) begin
			rnd = (n == 0) ? 32'h18 : (n == 1) ? 32'hFF : $urandom();
			path <= rnd[7:0];
			rd_chk(OFS_LIVE, live_img(rnd[7:0]));
		end
		do_reset();
		report_and_stop();
	end
endmodule // test_rvg_regs
`default_nettype wire
